// >>> rtl/sdpi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_defs.svh"
module sdpi_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [27:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_byte_en,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  input  wire logic [1:0]  pair_wide,
  input  wire logic [1:0]  pair_bank2,
  input  wire logic [7:0]  pair_row_bits,
  input  wire logic [7:0]  pair_col_bits,
  input  wire logic [7:0]  pair_half_period,
  input  wire logic        legacy_map,
  input  wire logic        low_power,
  output logic [1:0]       memory_clock_out,
  output logic             memory_clock_enable,
  output logic [3:0]       partition_select_n,
  output logic [14:0]      memory_address_out,
  output logic             row_strobe_n,
  output logic             column_strobe_n,
  output logic             write_enable_n,
  output logic [3:0]       byte_mask,
  input  wire logic [31:0] memory_data_bus_in,
  output logic [31:0]      memory_data_bus_out,
  output logic             memory_data_bus_oe,
  output logic             transceiver_direction
);
  sdpi_pkg::sdpi_state_t st_r, st_nxt;
  logic [1:0]  fall;
  logic [1:0]  part_r, part_nxt;
  logic        wr_r, wr_nxt, ready_r, ready_nxt, rvalid_r, rvalid_nxt;
  logic        oe_r, oe_nxt, dir_r, dir_nxt, cke_r, cke_nxt;
  logic [12:0] row_r, row_nxt;
  logic [10:0] col_r, col_nxt;
  logic [1:0]  bank_r, bank_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, dout_r, dout_nxt;
  logic [3:0]  be_r, be_nxt, dqm_r, dqm_nxt, cs_n_r, cs_n_nxt, cnt_r, cnt_nxt;
  logic [2:0]  cmd_r, cmd_nxt;
  logic [14:0] addr_r, addr_nxt;
  logic [31:0] md_s1_r, md_s2_r;
  logic        step, wide, rq_wide;
  logic [3:0]  rq_rows, rq_cols;
  logic [24:0] off;
  sdpi_map_if  mi ();

  // Per-pair memory clock divider, enable on falling edge
  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    logic [3:0] cnt_r, cnt_nxt, half;
    logic       clk_r, clk_nxt, wrap;
    always_comb
    begin
      half = (pair_half_period[4*p +: 4] < `SDPI_MIN_HALF) ? `SDPI_MIN_HALF
             : pair_half_period[4*p +: 4];
      wrap = (cnt_r >= half - 4'h1);
      cnt_nxt = wrap ? 4'h0 : cnt_r + 4'h1;
      clk_nxt = wrap ? ~clk_r : clk_r;
    end
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        cnt_r <= 4'h0;
        clk_r <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_nxt;
        clk_r <= clk_nxt;
      end
    end
    assign fall[p] = wrap & clk_r;
    assign memory_clock_out[p] = clk_r;
  end

  // Two-stage sync of the data pins
  always_ff @(posedge core_clk)
  begin
    md_s1_r <= memory_data_bus_in;
    md_s2_r <= md_s1_r;
  end

  // Geometry of the current partition to the mapper
  assign mi.col_phase = (st_r == sdpi_pkg::ST_RCD);
  assign mi.row       = row_r;
  assign mi.col       = col_r;
  assign mi.bank      = bank_r;
  assign mi.bank2     = pair_bank2[part_r[1]];
  assign mi.row_bits  = pair_row_bits[{part_r[1], 2'h0} +: 4];
  assign mi.col_bits  = pair_col_bits[{part_r[1], 2'h0} +: 4];
  assign mi.legacy    = legacy_map;

  sdpi_addr_map u_map (
    .mi (mi)
  );

  // Request split into column, row and bank within the window
  always_comb
  begin
    rq_wide = pair_wide[req_addr[27]];
    rq_rows = pair_row_bits[{req_addr[27], 2'h0} +: 4];
    rq_cols = pair_col_bits[{req_addr[27], 2'h0} +: 4];
    off = rq_wide ? {1'b0, req_addr[25:2]} : req_addr[25:1];
  end

  // Access sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    part_nxt = part_r;
    wr_nxt = wr_r;
    row_nxt = row_r;
    col_nxt = col_r;
    bank_nxt = bank_r;
    wdata_nxt = wdata_r;
    be_nxt = be_r;
    ready_nxt = ready_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    cmd_nxt = cmd_r;
    cs_n_nxt = cs_n_r;
    addr_nxt = addr_r;
    dqm_nxt = dqm_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    dir_nxt = dir_r;
    cnt_nxt = cnt_r;
    cke_nxt = !(low_power && st_r == sdpi_pkg::ST_IDLE);
    step = fall[part_r[1]];
    wide = pair_wide[part_r[1]];
    unique case (st_r)
      sdpi_pkg::ST_IDLE:
      begin
        if (req_valid && ready_r)
        begin
          part_nxt = req_addr[`SDPI_WINDOW_BITS +: 2];
          wr_nxt = req_write;
          col_nxt = 11'(off & ((25'h1 << rq_cols) - 25'h1));
          row_nxt = 13'((off >> rq_cols) & ((25'h1 << rq_rows) - 25'h1));
          // Five-bit sum: 13 rows plus 11 columns overflows four bits
          bank_nxt = 2'(off >> (5'(rq_cols) + 5'(rq_rows))) & {pair_bank2[req_addr[27]], 1'b1};
          wdata_nxt = req_wdata;
          be_nxt = req_byte_en;
          ready_nxt = 1'b0;
          st_nxt = sdpi_pkg::ST_ACT;
        end
        else
          ready_nxt = 1'b1;
      end
      sdpi_pkg::ST_ACT:
      begin
        if (step)
        begin
          cmd_nxt = `SDPI_CMD_ACT;
          cs_n_nxt = ~(4'h1 << part_r);
          addr_nxt = mi.pins;
          cnt_nxt = 4'h1;
          st_nxt = sdpi_pkg::ST_RCD;
        end
      end
      sdpi_pkg::ST_RCD:
      begin
        if (step && cnt_r == `SDPI_TRCD_CLKS)
        begin
          cmd_nxt = wr_r ? `SDPI_CMD_WRITE : `SDPI_CMD_READ;
          cs_n_nxt = ~(4'h1 << part_r);
          addr_nxt = mi.pins;
          dqm_nxt = wr_r ? ~(be_r & {{2{wide}}, 2'h3}) : {{2{~wide}}, 2'h0};
          oe_nxt = wr_r;
          dir_nxt = ~wr_r;
          dout_nxt = wdata_r;
          cnt_nxt = 4'h1;
          st_nxt = sdpi_pkg::ST_XFER;
        end
        else if (step)
        begin
          cmd_nxt = `SDPI_CMD_NOP;
          cs_n_nxt = 4'hF;
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      sdpi_pkg::ST_XFER:
      begin
        if (step)
        begin
          cmd_nxt = `SDPI_CMD_NOP;
          cs_n_nxt = 4'hF;
          oe_nxt = 1'b0;
          dir_nxt = 1'b1;
          cnt_nxt = cnt_r + 4'h1;
          // One step past the latency edge: the pin sync costs two core cycles
          if (!wr_r && cnt_r == `SDPI_CAS_LAT + 4'h1)
          begin
            rdata_nxt = wide ? md_s2_r : {16'h0000, md_s2_r[15:0]};
            rvalid_nxt = 1'b1;
          end
          if (cnt_r == `SDPI_TAIL_CLKS)
          begin
            dqm_nxt = 4'h0;
            ready_nxt = 1'b1;
            st_nxt = sdpi_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // Access sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= sdpi_pkg::ST_IDLE;
      part_r <= 2'h0;
      wr_r <= 1'b0;
      row_r <= 13'h0000;
      col_r <= 11'h000;
      bank_r <= 2'h0;
      wdata_r <= 32'h0000_0000;
      be_r <= 4'h0;
      ready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      cmd_r <= `SDPI_CMD_NOP;
      cs_n_r <= 4'hF;
      addr_r <= 15'h0000;
      dqm_r <= 4'h0;
      dout_r <= 32'h0000_0000;
      oe_r <= 1'b0;
      dir_r <= 1'b1;
      cnt_r <= 4'h0;
      cke_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      part_r <= part_nxt;
      wr_r <= wr_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      bank_r <= bank_nxt;
      wdata_r <= wdata_nxt;
      be_r <= be_nxt;
      ready_r <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      cmd_r <= cmd_nxt;
      cs_n_r <= cs_n_nxt;
      addr_r <= addr_nxt;
      dqm_r <= dqm_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      dir_r <= dir_nxt;
      cnt_r <= cnt_nxt;
      cke_r <= cke_nxt;
    end
  end

  // Pins straight from the registers
  assign req_ready = ready_r;
  assign rsp_valid = rvalid_r;
  assign rsp_rdata = rdata_r;
  assign memory_clock_enable = cke_r;
  assign partition_select_n = cs_n_r;
  assign memory_address_out = addr_r;
  assign {row_strobe_n, column_strobe_n, write_enable_n} = cmd_r;
  assign byte_mask = dqm_r;
  assign memory_data_bus_out = dout_r;
  assign memory_data_bus_oe = oe_r;
  assign transceiver_direction = dir_r;

  // Checks on the pin behaviour
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_mclk_rate: assert property ($changed(memory_clock_out[0])
    |-> $past(g_pair[0].cnt_r) + 4'h1 >= `SDPI_MIN_HALF)
    else $error("memory clock above limit");
  a_pair_clock: assert property ($fell(&partition_select_n[3:2])
    |-> $fell(memory_clock_out[1]))
    else $error("pair 2/3 command not on its clock");
  a_pair0_clock: assert property ($fell(&partition_select_n[1:0])
    |-> $fell(memory_clock_out[0]))
    else $error("pair 0/1 command not on its clock");
  a_cke_busy: assert property (st_r != sdpi_pkg::ST_IDLE |=> memory_clock_enable)
    else $error("clock enable low during access");
  a_cs_onehot: assert property ($onehot0(~partition_select_n))
    else $error("more than one partition selected");
  a_window_part: assert property (req_valid && req_ready |=> part_r == $past(req_addr[27:26]))
    else $error("partition not from window bits");
  a_read_narrow: assert property (cmd_r == `SDPI_CMD_READ && !pair_wide[part_r[1]]
    |-> byte_mask == 4'hC)
    else $error("narrow read mask wrong");
  a_write_mask: assert property (cmd_r == `SDPI_CMD_WRITE && $changed(cmd_r)
    |-> byte_mask[1:0] == ~be_r[1:0] && !transceiver_direction)
    else $error("write mask or direction wrong");
  a_dir_oe: assert property (memory_data_bus_oe == !transceiver_direction)
    else $error("direction disagrees with drive");
  a_act_to_col: assert property ($fell(row_strobe_n) && column_strobe_n
    |-> ##[2:200] !column_strobe_n)
    else $error("no column command after activate");
  a_normal_bank: assert property ($fell(row_strobe_n) && !legacy_map && !mi.bank2
    |-> memory_address_out[mi.row_bits] == bank_r[0] && memory_address_out[0] == row_r[0])
    else $error("normal bank placement wrong");
  a_legacy_bank: assert property ($fell(row_strobe_n) && legacy_map && !mi.bank2
    |-> memory_address_out[11] == bank_r[0])
    else $error("legacy bank not on pin 21");
endmodule : sdpi_top
`default_nettype wire

// >>> rtl/sdpi_defs.svh
`ifndef SDPI_DEFS_SVH
`define SDPI_DEFS_SVH
// Memory clock limit and core rate
`define SDPI_CORE_MHZ 100
`define SDPI_MCLK_MAX_MHZ 100
// Least half period in core cycles, rounded up
`define SDPI_MIN_HALF 4'((`SDPI_CORE_MHZ + 2 * `SDPI_MCLK_MAX_MHZ - 1) / (2 * `SDPI_MCLK_MAX_MHZ))
// Partition window and address pin field
`define SDPI_WINDOW_BITS 26
`define SDPI_PIN_LO 10
`define SDPI_PIN_W 15
`define SDPI_LEGACY_BS0 4'hB
// Command codes as {ras_n, cas_n, we_n}
`define SDPI_CMD_NOP 3'h7
`define SDPI_CMD_ACT 3'h3
`define SDPI_CMD_READ 3'h5
`define SDPI_CMD_WRITE 3'h4
// Timing in memory clock cycles
`define SDPI_TRCD_CLKS 4'h2
`define SDPI_CAS_LAT 4'h2
`define SDPI_TAIL_CLKS 4'h5
`endif

// >>> rtl/sdpi_pkg.sv
package sdpi_pkg;
  // Access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACT  = 4'h2,
    ST_RCD  = 4'h4,
    ST_XFER = 4'h8
  } sdpi_state_t;
endpackage : sdpi_pkg

// >>> rtl/sdpi_map_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdpi_map_if;
  logic        col_phase;
  logic [12:0] row;
  logic [10:0] col;
  logic [1:0]  bank;
  logic        bank2;
  logic [3:0]  row_bits;
  logic [3:0]  col_bits;
  logic        legacy;
  logic [14:0] pins;
  modport ctrl (output col_phase, row, col, bank, bank2, row_bits, col_bits, legacy,
                input pins);
  modport mapper (input col_phase, row, col, bank, bank2, row_bits, col_bits, legacy,
                  output pins);
endinterface : sdpi_map_if
`default_nettype wire

// >>> rtl/sdpi_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
module sdpi_addr_map (
  sdpi_map_if.mapper mi
);
  logic [12:0] dev_a;
  logic        tall8;

  // Device address: row, or column with auto-precharge on A10
  always_comb
  begin
    if (mi.col_phase)
      dev_a = {1'b0, mi.col[10], 1'b1, mi.col[9:0]};
    else
      dev_a = mi.row;
    tall8 = mi.bank2 && (mi.row_bits == 4'hD) && (mi.col_bits == 4'h8);
  end

  // One pin of the field per iteration
  for (genvar i = 0; i < 15; i++)
  begin : g_pin
    localparam logic [3:0] IDX    = 4'(i);
    // Device bit for this pin, and for a pin shifted up by the bank
    localparam int         BIT    = (i < 13) ? i : 0;
    localparam int         BIT_DN = (i > 0 && i < 14) ? i - 1 : 0;
    always_comb
    begin
      mi.pins[i] = 1'b0;
      if (mi.legacy && !mi.bank2)
      begin
        // Bank fixed at pin 21, device bits 11 and 12 above it
        if (i < 11)
          mi.pins[i] = dev_a[BIT];
        else if (IDX == `SDPI_LEGACY_BS0)
          mi.pins[i] = mi.bank[0];
        else if (i < 14)
          mi.pins[i] = dev_a[BIT_DN];
      end
      else if (mi.legacy && tall8)
      begin
        // Row 12 moves above both banks
        if (i < 12)
          mi.pins[i] = dev_a[BIT];
        else if (i == 12)
          mi.pins[i] = mi.bank[0];
        else if (i == 13)
          mi.pins[i] = mi.bank[1];
        else
          mi.pins[i] = dev_a[12];
      end
      else
      begin
        // Rows from pin 10 upward, banks right above top row
        if (IDX < mi.row_bits)
          mi.pins[i] = dev_a[BIT];
        else if (IDX == mi.row_bits)
          mi.pins[i] = mi.bank[0];
        else if (IDX == mi.row_bits + 4'h1)
          mi.pins[i] = mi.bank2 & mi.bank[1];
      end
    end
  end
endmodule : sdpi_addr_map
`default_nettype wire

// >>> test/sdpi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_defs.svh"
// Behavioural memory behind one partition pair
module sdpi_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  cs_n,
  input  wire logic [2:0]  cmd,
  input  wire logic [14:0] addr,
  input  wire logic [3:0]  mask,
  input  wire logic [31:0] dq_in,
  output logic [31:0]      dq_out,
  output logic             dq_oe
);
  logic [31:0] mem [logic [31:0]];
  logic [14:0] row_r;
  logic [31:0] rd_r;
  logic [31:0] w_r;
  logic [2:0]  pipe_r;
  logic [31:0] key;

  // Word driven one to three clocks after a read, inverted once released
  initial pipe_r = 3'h0;
  initial rd_r = 32'h0000_0000;
  assign dq_oe  = pipe_r[1] | pipe_r[2];
  assign dq_out = dq_oe ? rd_r : ~rd_r;
  assign key    = {cs_n, row_r, addr & 15'h7BFF};

  // Commands sampled on the rising memory clock
  always @(posedge clk)
  begin
    pipe_r <= {pipe_r[1:0], 1'b0};
    if (cs_n != 2'h3 && cmd == `SDPI_CMD_ACT)
      row_r <= addr;
    if (cs_n != 2'h3 && cmd == `SDPI_CMD_WRITE)
    begin
      w_r = mem.exists(key) ? mem[key] : 32'h0000_0000;
      for (int b = 0; b < 4; b++)
        if (!mask[b]) w_r[8*b+:8] = dq_in[8*b+:8];
      mem[key] = w_r;
    end
    if (cs_n != 2'h3 && cmd == `SDPI_CMD_READ)
    begin
      rd_r <= mem.exists(key) ? mem[key] : 32'h0000_0000;
      pipe_r[0] <= 1'b1;
    end
  end
endmodule : sdpi_mem_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_defs.svh"
module testbench;
  logic        core_clk, rst, req_valid, req_ready, req_write, rsp_valid, saw_oe;
  logic        legacy_map, low_power, cke, ras_n, cas_n, we_n, bus_oe, dir, m0_oe, m1_oe;
  logic [27:0] req_addr;
  logic [31:0] req_wdata, rsp_rdata, bus_in, bus_out, m0_dq, m1_dq, rd;
  logic [3:0]  req_byte_en, cs_n, dqm;
  logic [1:0]  pair_wide, pair_bank2, mclk, bad;
  logic [7:0]  pair_row_bits, pair_col_bits, pair_half_period;
  logic [14:0] ma, act_p, col_p;
  logic [6:0]  ccmd;
  int          error_cnt, total_checks, cyc;

  // Block and one memory model per pair; data bus resolved here
  assign bus_in = bus_oe ? bus_out : (m0_oe ? m0_dq : m1_dq);
  sdpi_top dut (
    .core_clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
    .req_byte_en, .rsp_valid, .rsp_rdata, .pair_wide, .pair_bank2, .pair_row_bits,
    .pair_col_bits, .pair_half_period, .legacy_map, .low_power,
    .memory_clock_out(mclk), .memory_clock_enable(cke), .partition_select_n(cs_n),
    .memory_address_out(ma), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .write_enable_n(we_n), .byte_mask(dqm), .memory_data_bus_in(bus_in),
    .memory_data_bus_out(bus_out), .memory_data_bus_oe(bus_oe),
    .transceiver_direction(dir)
  );
  sdpi_mem_model m0 (.clk(mclk[0]), .cs_n(cs_n[1:0]), .cmd({ras_n, cas_n, we_n}), .addr(ma),
    .mask(dqm), .dq_in(bus_out), .dq_out(m0_dq), .dq_oe(m0_oe));
  sdpi_mem_model m1 (.clk(mclk[1]), .cs_n(cs_n[3:2]), .cmd({ras_n, cas_n, we_n}), .addr(ma),
    .mask(dqm), .dq_in(bus_out), .dq_out(m1_dq), .dq_oe(m1_oe));

  // Clock and hang guard
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // Expected row pins, or column pins when colp is set
  function automatic logic [14:0] exp_pins(input logic [27:0] a, input logic wide,
    input logic b2, input int rb, input int cb, input logic leg, input logic colp);
    logic [25:0] off;
    logic [12:0] row;
    logic [10:0] col;
    logic [1:0]  bk;
    logic [12:0] dev;
    off = wide ? {2'h0, a[25:2]} : {1'b0, a[25:1]};
    col = 11'(off & ((26'h1 << cb) - 26'h1));
    row = 13'((off >> cb) & ((26'h1 << rb) - 26'h1));
    bk  = 2'((off >> (cb + rb)) & (b2 ? 26'h3 : 26'h1));
    // Column form carries auto-precharge on A10; banks ride along in both phases
    dev = colp ? {1'b0, col[10], 1'b1, col[9:0]} : row;
    if (leg && !b2) return {1'b0, dev[12:11], bk[0], dev[10:0]};
    if (leg && rb == 13 && cb == 8) return {dev[12], bk, dev[11:0]};
    return (15'(bk) << rb) | 15'(dev & ((13'h1 << rb) - 13'h1));
  endfunction : exp_pins

  // One request, watched until the block is ready again
  task automatic access(input logic wr, input logic [27:0] a, input logic [31:0] wd,
    input logic [3:0] be);
    int n;
    logic [3:0] cs_exp;
    n = 0;
    cs_exp = ~(4'h1 << a[27:26]);
    bad = 2'h0;
    saw_oe = 1'b0;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    req_byte_en = be;
    while (req_ready !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    do
    begin
      @(negedge core_clk);
      req_valid = 1'b0;
      n++;
      if (cs_n !== 4'hF && cs_n !== cs_exp) bad[0] = 1'b1;
      if (dir !== ~bus_oe) bad[1] = 1'b1;
      if (bus_oe === 1'b1) saw_oe = 1'b1;
      if (cs_n !== 4'hF && !ras_n) act_p = ma;
      if (cs_n !== 4'hF && !cas_n) col_p = ma;
      if (cs_n !== 4'hF && !cas_n) ccmd = {ras_n, cas_n, we_n, dqm};
      if (rsp_valid === 1'b1) rd = rsp_rdata;
    end while (req_ready !== 1'b1 && n < 600);
    chk("select and direction", 32'h0, 32'(bad));
    chk("access end", 32'h1, 32'(req_ready));
  endtask : access

  // Pair clocks run at their own rates
  task automatic t_clocks;
    int t0;
    int t1;
    logic [1:0] prev;
    t0 = 0;
    t1 = 0;
    @(negedge core_clk);
    prev = mclk;
    repeat (24)
    begin
      @(negedge core_clk);
      t0 += int'(mclk[0] !== prev[0]);
      t1 += int'(mclk[1] !== prev[1]);
      prev = mclk;
    end
    chk("pair 0 clock edges", 32'd12, t0);
    chk("pair 1 clock edges", 32'd8, t1);
  endtask : t_clocks

  // Clock enable follows the low power request while idle
  task automatic t_power;
    low_power = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("clock enable low", 32'h0, 32'(cke));
    low_power = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("clock enable high", 32'h1, 32'(cke));
  endtask : t_power

  // Wide pair: masked write, partition windows, read back
  task automatic t_wide;
    logic [27:0] a;
    a = 28'h5A5_6788;
    access(1'b1, a, 32'hCAFE_F00D, 4'hF);
    chk("row pins", 32'(exp_pins(a, 1'b1, 1'b1, 13, 9, 1'b0, 1'b0)), 32'(act_p));
    chk("column pins", 32'(exp_pins(a, 1'b1, 1'b1, 13, 9, 1'b0, 1'b1)), 32'(col_p));
    chk("write drive", 32'h1, 32'(saw_oe));
    access(1'b1, a, 32'h1122_3344, 4'h5);
    chk("write command and mask", 32'({`SDPI_CMD_WRITE, 4'hA}), 32'(ccmd));
    access(1'b1, a ^ 28'h400_0000, 32'h5555_AAAA, 4'hF);
    access(1'b0, a, 32'h0000_0000, 4'hF);
    chk("read data", 32'hCA22_F044, rd);
    chk("read command", 32'(`SDPI_CMD_READ), 32'(ccmd[6:4]));
    chk("read drive", 32'h0, 32'(saw_oe));
  endtask : t_wide

  // Narrow pair through normal and legacy geometries
  task automatic t_geom;
    logic [11:0] geo [7] = '{12'h0B8, 12'h1D8, 12'h3D8, 12'h2CA, 12'h1CB, 12'h2DA, 12'h3C9};
    logic [27:0] a;
    a = 28'hEB6_D5A6;
    for (int i = 0; i < 7; i++)
    begin
      pair_bank2[1] = geo[i][9];
      legacy_map = geo[i][8];
      pair_row_bits[7:4] = geo[i][7:4];
      pair_col_bits[7:4] = geo[i][3:0];
      access(1'b1, a, 32'hBEEF_1230 + i, 4'hF);
      chk("row pins", 32'(exp_pins(a, 1'b0, geo[i][9], geo[i][7:4], geo[i][3:0], geo[i][8],
        1'b0)), 32'(act_p));
      chk("column pins", 32'(exp_pins(a, 1'b0, geo[i][9], geo[i][7:4], geo[i][3:0], geo[i][8],
        1'b1)), 32'(col_p));
      access(1'b0, a, 32'h0000_0000, 4'hF);
      chk("narrow read", 32'h0000_1230 + i, rd);
    end
  endtask : t_geom

  // Main sequence
  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 28'h000_0000;
    req_wdata = 32'h0000_0000;
    req_byte_en = 4'h0;
    pair_wide = 2'h1;
    pair_bank2 = 2'h1;
    pair_row_bits = 8'hBD;
    pair_col_bits = 8'h89;
    pair_half_period = 8'h32;
    legacy_map = 1'b0;
    low_power = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("idle outputs", 32'hFF0, 32'({cs_n, ras_n, cas_n, we_n, dir, dqm}));
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("clock enable", 32'h1, 32'(cke));
    t_clocks();
    t_power();
    t_wide();
    t_geom();
    conclude();
  end
endmodule : testbench
`default_nettype wire
